// ===== core/sbfr_top.sv
// Behaviour
// - First sync byte 86 or 30 sets baud rate, echoed; silent on failure.
// - Second sync byte 79 or CF echoed when accepted, silent on error.
// - Operation code 40 selects flash read and is echoed back.
// - Opcode stage failure sends one error code three times, then idles.
// - Top region all FF skips password check; string may be omitted.
// - Bad password address stops communication silently, permanent idle until reset.
// - Security enabled or password mismatch stops communication, idle.
// - Framing error during password fields or string stops communication, idle.
// - Count zero or above memory size stops communication, idle.
// - No reply to any address or count byte, good or bad.
// - Accepted count streams memory bytes from start address at adjusted rate.
// - Two checksum bytes follow data, high first; none after an error.
// - After checksum, wait for next opcode at the same rate.
`timescale 1ns/100ps
module sbfr_top #(
   parameter int CNT_W = 16,
   parameter logic [23:0] MEM_SIZE = 24'h010000
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Serial link pins
   input wire logic rxd,
   output logic txd,
   // Security program flag from flash
   input wire logic sec_en,
   // Flash read port, data one cycle after the strobe
   output logic mem_rd,
   output logic [23:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   // Status
   output logic locked
);

   typedef enum {S_START, S_BLOW, S_BHIGH, S_BIDLE, S_TX, S_SYNC2, S_OPC, S_PWADR, S_SCAN,
                 S_PWCNT, S_PWSTR, S_RDADR, S_RDDAT, S_CKHI, S_CKLO, S_ERRTX, S_DEAD} sbfr_state_e;

   // ---------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------
   logic [2:0] rx_sync_r;
   logic rx_lvl_r;

   // Level only follows once the second and third stages agree
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_sync_r <= 3'b111;
         rx_lvl_r <= 1'b1;
      end
      else if (clk_en)
      begin
         rx_sync_r <= {rx_sync_r[1:0], rxd};
         if (rx_sync_r[1] == rx_sync_r[2])
            rx_lvl_r <= rx_sync_r[2];
      end
   end

   // ---------------------------------------------------------------
   // Serial byte engine
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] bit_per_r;
   logic rx_en_r;
   logic rx_valid;
   logic [7:0] rx_data;
   logic rx_ferr;
   logic tx_req_r;
   logic [7:0] tx_byte_r;
   logic tx_busy;
   logic uart_txd;

   sbfr_uart #(.CNT_W(CNT_W)) u_uart (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .bit_per(bit_per_r),
      .rx_en(rx_en_r),
      .rx_lvl(rx_lvl_r),
      .rx_valid(rx_valid),
      .rx_data(rx_data),
      .rx_ferr(rx_ferr),
      .tx_req(tx_req_r),
      .tx_byte(tx_byte_r),
      .tx_busy(tx_busy),
      .txd(uart_txd)
   );

   // Output pin straight from a flop
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         txd <= 1'b1;
      else if (clk_en)
         txd <= uart_txd;
   end

   // ---------------------------------------------------------------
   // Sync byte classification
   // ---------------------------------------------------------------
   // Both sync values carry a two-bit high run after the first low run;
   // low run is two bits for 86 and five bits for 30. Returns 1, 2 or 0.
   function automatic logic [1:0] sync1_kind(input logic [CNT_W-1:0] lo, input logic [CNT_W-1:0] hi);
      logic [CNT_W+3:0] l1;
      logic [CNT_W+3:0] h1;
      logic [CNT_W+3:0] tol;
      l1 = {4'h0, lo};
      h1 = {4'h0, hi};
      tol = h1 >> 2;
      sync1_kind = 2'h0;
      if (l1 + tol >= h1 && l1 <= h1 + tol)
         sync1_kind = 2'h1;
      else if ((l1 << 1) + (tol << 1) >= h1 * 5 && (l1 << 1) <= h1 * 5 + (tol << 1))
         sync1_kind = 2'h2;
   endfunction

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   sbfr_state_e state_r;
   sbfr_state_e ret_r;
   logic [CNT_W-1:0] meas_r;
   logic [CNT_W-1:0] low_len_r;
   logic [47:0] sh_r;
   logic [2:0] idx_r;
   logic [23:0] ptr_r;
   logic [23:0] left_r;
   logic [15:0] sum_r;
   logic [1:0] err_n_r;
   logic blank_r;
   logic mem_pend_r;
   logic [1:0] kind;
   logic [47:0] sh_nxt;
   logic tx_idle;

   assign kind = sync1_kind(low_len_r, meas_r);
   assign sh_nxt = {sh_r[39:0], rx_data};
   assign tx_idle = !tx_busy && !tx_req_r;

   // One process: the sequence, the memory strobe and the reply byte are tied
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= S_START;
         ret_r <= S_START;
         meas_r <= '0;
         low_len_r <= '0;
         bit_per_r <= '0;
         rx_en_r <= 1'b0;
         tx_req_r <= 1'b0;
         tx_byte_r <= 8'h00;
         sh_r <= 48'h0;
         idx_r <= 3'h0;
         ptr_r <= 24'h0;
         left_r <= 24'h0;
         sum_r <= sbfr_pkg::SUM_RST;
         err_n_r <= 2'h0;
         blank_r <= 1'b1;
         mem_pend_r <= 1'b0;
         mem_rd <= 1'b0;
         mem_addr <= 24'h0;
         locked <= 1'b0;
      end
      else if (clk_en)
      begin
         tx_req_r <= 1'b0;
         mem_rd <= 1'b0;
         mem_pend_r <= mem_rd;
         unique case (state_r)
            S_START:
               // This low cycle already counts, or the measured bit comes out one short
               if (!rx_lvl_r)
               begin
                  meas_r <= CNT_W'(1);
                  state_r <= S_BLOW;
               end
            S_BLOW:
               if (rx_lvl_r)
               begin
                  low_len_r <= meas_r;
                  meas_r <= CNT_W'(1);
                  state_r <= S_BHIGH;
               end
               else if (meas_r != '1)
                  meas_r <= meas_r + 1'b1;
            S_BHIGH:
               if (!rx_lvl_r)
               begin
                  if (kind == 2'h0 || meas_r[CNT_W-1:1] == '0)
                     state_r <= S_DEAD;
                  else
                  begin
                     bit_per_r <= meas_r >> 1;
                     tx_byte_r <= (kind == 2'h1) ? sbfr_pkg::SYNC1_A : sbfr_pkg::SYNC1_B;
                     meas_r <= '0;
                     state_r <= S_BIDLE;
                  end
               end
               else if (meas_r != '1)
                  meas_r <= meas_r + 1'b1;
               else
                  state_r <= S_DEAD;
            S_BIDLE:
               // Wait out the tail of the byte before the echo
               if (!rx_lvl_r)
                  meas_r <= '0;
               else if (meas_r >= bit_per_r * sbfr_pkg::IDLE_BIT_TIMES)
               begin
                  rx_en_r <= 1'b1;
                  ret_r <= S_SYNC2;
                  state_r <= S_TX;
               end
               else
                  meas_r <= meas_r + 1'b1;
            S_TX:
               if (tx_idle)
               begin
                  tx_req_r <= 1'b1;
                  state_r <= ret_r;
               end
            S_SYNC2:
               if (rx_ferr)
                  state_r <= S_DEAD;
               else if (rx_valid)
               begin
                  if (rx_data == sbfr_pkg::SYNC2_A || rx_data == sbfr_pkg::SYNC2_B)
                  begin
                     tx_byte_r <= rx_data;
                     ret_r <= S_OPC;
                     state_r <= S_TX;
                  end
                  else
                     state_r <= S_DEAD;
               end
            S_OPC:
               if (rx_ferr || (rx_valid && rx_data != sbfr_pkg::OPC_READ))
               begin
                  tx_byte_r <= rx_ferr ? sbfr_pkg::ERR_FRAME : sbfr_pkg::ERR_OPCODE;
                  err_n_r <= 2'h0;
                  state_r <= S_ERRTX;
               end
               else if (rx_valid)
               begin
                  tx_byte_r <= rx_data;
                  idx_r <= 3'h0;
                  ret_r <= S_PWADR;
                  state_r <= S_TX;
               end
            S_ERRTX:
               if (tx_idle)
               begin
                  if (err_n_r == sbfr_pkg::ERR_REPEAT)
                     state_r <= S_DEAD;
                  else
                  begin
                     tx_req_r <= 1'b1;
                     err_n_r <= err_n_r + 2'h1;
                  end
               end
            S_PWADR:
               if (rx_ferr)
                  state_r <= S_DEAD;
               else if (rx_valid)
               begin
                  sh_r <= sh_nxt;
                  idx_r <= idx_r + 3'h1;
                  if (idx_r == sbfr_pkg::ADDR_FIELD_LAST)
                  begin
                     if (sec_en)
                        state_r <= S_DEAD;
                     else if (sh_nxt[47:24] >= MEM_SIZE || sh_nxt[23:0] >= MEM_SIZE)
                        state_r <= S_DEAD;
                     else
                     begin
                        ptr_r <= sbfr_pkg::BLANK_LO;
                        blank_r <= 1'b1;
                        state_r <= S_SCAN;
                     end
                  end
               end
            S_SCAN:
               if (mem_pend_r && mem_addr == sbfr_pkg::BLANK_HI)
               begin
                  idx_r <= 3'h0;
                  if (blank_r && mem_rdata == sbfr_pkg::BLANK_VAL)
                     state_r <= S_RDADR;
                  else
                  begin
                     mem_rd <= 1'b1;
                     mem_addr <= sh_r[47:24];
                     state_r <= S_PWCNT;
                  end
               end
               else if (!mem_rd)
               begin
                  // Next read overlaps this check, so the scan ends before the next host byte
                  if (mem_pend_r && mem_rdata != sbfr_pkg::BLANK_VAL)
                     blank_r <= 1'b0;
                  mem_rd <= 1'b1;
                  mem_addr <= ptr_r;
                  ptr_r <= ptr_r + 24'h1;
               end
            S_PWCNT:
               if (mem_pend_r)
               begin
                  if (mem_rdata == 8'h00)
                     state_r <= S_DEAD;
                  else
                  begin
                     left_r <= {16'h0, mem_rdata};
                     ptr_r <= sh_r[23:0];
                     state_r <= S_PWSTR;
                  end
               end
            S_PWSTR:
               if (rx_ferr)
                  state_r <= S_DEAD;
               else if (rx_valid)
               begin
                  tx_byte_r <= rx_data;
                  mem_rd <= 1'b1;
                  mem_addr <= ptr_r;
                  ptr_r <= ptr_r + 24'h1;
               end
               else if (mem_pend_r)
               begin
                  if (mem_rdata != tx_byte_r)
                     state_r <= S_DEAD;
                  else if (left_r == 24'h1)
                  begin
                     idx_r <= 3'h0;
                     state_r <= S_RDADR;
                  end
                  left_r <= left_r - 24'h1;
               end
            S_RDADR:
               if (rx_ferr)
                  state_r <= S_DEAD;
               else if (rx_valid)
               begin
                  sh_r <= sh_nxt;
                  idx_r <= idx_r + 3'h1;
                  if (idx_r == sbfr_pkg::ADDR_FIELD_LAST)
                  begin
                     if (sh_nxt[23:0] == sbfr_pkg::COUNT_ZERO || sh_nxt[23:0] > MEM_SIZE)
                        state_r <= S_DEAD;
                     else
                     begin
                        ptr_r <= sh_nxt[47:24];
                        left_r <= sh_nxt[23:0];
                        sum_r <= sbfr_pkg::SUM_RST;
                        state_r <= S_RDDAT;
                     end
                  end
               end
            S_RDDAT:
               if (mem_pend_r)
               begin
                  tx_byte_r <= mem_rdata;
                  tx_req_r <= 1'b1;
                  sum_r <= sum_r + {8'h00, mem_rdata};
                  left_r <= left_r - 24'h1;
               end
               else if (left_r == 24'h0)
               begin
                  if (tx_idle)
                  begin
                     tx_byte_r <= sum_r[15:8];
                     ret_r <= S_CKHI;
                     state_r <= S_TX;
                  end
               end
               else if (tx_idle && !mem_rd)
               begin
                  mem_rd <= 1'b1;
                  mem_addr <= ptr_r;
                  ptr_r <= ptr_r + 24'h1;
               end
            S_CKHI:
               begin
                  tx_byte_r <= sum_r[7:0];
                  ret_r <= S_CKLO;
                  state_r <= S_TX;
               end
            S_CKLO:
               state_r <= S_OPC;
            S_DEAD:
               begin
                  rx_en_r <= 1'b0;
                  // A frame already on the wire finishes before the lock shows
                  if (tx_idle)
                     locked <= 1'b1;
               end
         endcase
      end
   end

endmodule

// ===== core/sbfr_pkg.sv
package sbfr_pkg;

   // ---------------------------------------------------------------
   // Byte values on the link and the error repeat count
   // ---------------------------------------------------------------
   localparam logic [7:0] SYNC1_A = 8'h86;
   localparam logic [7:0] SYNC1_B = 8'h30;
   localparam logic [7:0] SYNC2_A = 8'h79;
   localparam logic [7:0] SYNC2_B = 8'hcf;
   localparam logic [7:0] OPC_READ = 8'h40;
   localparam logic [7:0] ERR_FRAME = 8'ha1;
   localparam logic [7:0] ERR_OPCODE = 8'h63;
   localparam logic [1:0] ERR_REPEAT = 2'h3;

   // ---------------------------------------------------------------
   // Memory layout and checks
   // ---------------------------------------------------------------
   localparam logic [23:0] BLANK_LO = 24'h00ffe0;
   localparam logic [23:0] BLANK_HI = 24'h00ffff;
   localparam logic [7:0] BLANK_VAL = 8'hff;
   localparam logic [23:0] COUNT_ZERO = 24'h000000;
   localparam logic [2:0] ADDR_FIELD_LAST = 3'h5;

   // ---------------------------------------------------------------
   // Serial framing and reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
   localparam logic [1:0] IDLE_BIT_TIMES = 2'h3;
   localparam logic [15:0] SUM_RST = 16'h0000;
   localparam logic [9:0] TX_LINE_IDLE = 10'h3ff;

endpackage

// ===== core/sbfr_uart.sv
`timescale 1ns/100ps
module sbfr_uart #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Rate and receive line
   input wire logic [CNT_W-1:0] bit_per,
   input wire logic rx_en,
   input wire logic rx_lvl,
   // Receive result
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_ferr,
   // Transmit request
   input wire logic tx_req,
   input wire logic [7:0] tx_byte,
   output logic tx_busy,
   output logic txd
);

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   logic rx_act_r;
   logic [3:0] rx_bit_r;
   logic [CNT_W-1:0] rx_cnt_r;
   logic [7:0] rx_sh_r;

   // Sample mid-bit; the first wait is half a bit to reach the centre
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_act_r <= 1'b0;
         rx_bit_r <= 4'h0;
         rx_cnt_r <= '0;
         rx_sh_r <= 8'h00;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
         rx_ferr <= 1'b0;
      end
      else if (clk_en)
      begin
         rx_valid <= 1'b0;
         rx_ferr <= 1'b0;
         if (!rx_act_r)
         begin
            if (rx_en && !rx_lvl)
            begin
               rx_act_r <= 1'b1;
               rx_bit_r <= 4'h0;
               rx_cnt_r <= bit_per >> 1;
            end
         end
         else if (rx_cnt_r != '0)
            rx_cnt_r <= rx_cnt_r - 1'b1;
         else
         begin
            rx_cnt_r <= bit_per - 1'b1;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && rx_lvl)
               rx_act_r <= 1'b0; // Glitch, not a start bit
            else if (rx_bit_r == sbfr_pkg::FRAME_LAST_BIT)
            begin
               rx_act_r <= 1'b0;
               rx_data <= rx_sh_r;
               rx_valid <= rx_lvl;
               rx_ferr <= !rx_lvl;
            end
            else if (rx_bit_r != 4'h0)
               rx_sh_r <= {rx_lvl, rx_sh_r[7:1]};
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   logic [9:0] tx_sh_r;
   logic [3:0] tx_bit_r;
   logic [CNT_W-1:0] tx_cnt_r;

   // Start bit, data LSB first, stop bit
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_sh_r <= sbfr_pkg::TX_LINE_IDLE;
         tx_bit_r <= 4'h0;
         tx_cnt_r <= '0;
         tx_busy <= 1'b0;
         txd <= 1'b1;
      end
      else if (clk_en)
      begin
         if (!tx_busy)
         begin
            if (tx_req)
            begin
               tx_sh_r <= {1'b1, tx_byte, 1'b0};
               tx_bit_r <= 4'h0;
               tx_cnt_r <= bit_per - 1'b1;
               tx_busy <= 1'b1;
               txd <= 1'b0;
            end
         end
         else if (tx_cnt_r != '0)
            tx_cnt_r <= tx_cnt_r - 1'b1;
         else if (tx_bit_r == sbfr_pkg::FRAME_LAST_BIT)
         begin
            tx_busy <= 1'b0;
            txd <= 1'b1;
         end
         else
         begin
            tx_cnt_r <= bit_per - 1'b1;
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            txd <= tx_sh_r[1];
         end
      end
   end

endmodule

// ===== tb/sbfr_top_props.sv
`timescale 1ns/100ps
module sbfr_top_props #(
   parameter int BIT_T = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Observed outputs
   input wire logic txd,
   input wire logic mem_rd,
   input wire logic [23:0] mem_addr,
   input wire logic locked
);
   // -----
   // Frame position tracker
   // -----
   logic txd_q_r;
   logic [7:0] fcnt_r;

   // Previous line level, idle high
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         txd_q_r <= 1'b1;
      else
         txd_q_r <= txd;

   // Wraps one cycle early so a back-to-back start is never missed
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         fcnt_r <= 8'h00;
      else if (fcnt_r != 8'h00)
         fcnt_r <= (fcnt_r == 10 * BIT_T - 1) ? 8'h00 : fcnt_r + 8'h01;
      else if (txd_q_r && !txd)
         fcnt_r <= 8'h01;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_rst_values: assert property ($fell(sys_rst) |-> txd && !mem_rd && !locked)
      else $error("outputs not idle after reset");
   chk_lock_holds: assert property (locked |=> locked)
      else $error("lock flag dropped");
   chk_lock_line_idle: assert property (locked |-> txd)
      else $error("line active while locked");
   chk_lock_no_read: assert property (locked |-> !mem_rd)
      else $error("memory read while locked");
   chk_read_spacing: assert property (mem_rd |=> !mem_rd)
      else $error("read strobes too close");
   chk_addr_hold: assert property (mem_rd |=> $stable(mem_addr))
      else $error("read address moved after strobe");
   chk_start_bit: assert property (fcnt_r != 8'h00 && fcnt_r < BIT_T |-> !txd)
      else $error("start bit too short");
   chk_stop_bit: assert property (fcnt_r >= 9 * BIT_T |-> txd)
      else $error("stop bit not high");
endmodule

// ===== tb/sbfr_host.sv
`timescale 1ns/100ps
module sbfr_host #(
   parameter int BIT_T = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Serial link, host side
   output logic rxd,
   input wire logic txd
);
   logic [8:0] rxq [$];
   logic [8:0] fr;

   // Line idles high
   initial rxd = 1'b1;

   // Start bit, data LSB first, stop bit, then idle bits
   task automatic send(input logic [7:0] b, input logic stop, input int gap);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd <= f[i];
         repeat (BIT_T) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (gap * BIT_T) @(posedge clk);
   endtask

   // Centre sampling; stop bit kept so framing slips show
   initial
      forever
      begin
         @(posedge clk);
         if (!sys_rst && txd === 1'b0)
         begin
            repeat (BIT_T / 2) @(posedge clk);
            for (int i = 0; i < 9; i++)
            begin
               repeat (BIT_T) @(posedge clk);
               fr[i] = txd;
            end
            rxq.push_back(fr);
         end
      end
endmodule

// ===== tb/sbfr_top_test.sv
`timescale 1ns/100ps
module sbfr_top_test;
   logic clk, sys_rst, clk_en, sec_en;
   logic [7:0] mem_rdata;
   logic [7:0] mem [0:65535];
   wire rxd, txd, mem_rd, locked;
   wire [23:0] mem_addr;
   int err_total, samples_checked;

   sbfr_top #(.CNT_W(16), .MEM_SIZE(24'h010000)) dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .rxd(rxd), .txd(txd), .sec_en(sec_en), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .locked(locked));
   sbfr_host #(.BIT_T(8)) host_u (.clk(clk), .sys_rst(sys_rst), .rxd(rxd), .txd(txd));

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Flash model, one cycle latency, frozen with the enable
   always @(posedge clk)
      if (mem_rd && clk_en)
         mem_rdata <= mem[mem_addr[15:0]];

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Next frame from the device, bounded wait
   task automatic get(input logic [7:0] exp);
      for (int n = 0; n < 4000 && host_u.rxq.size() == 0; n++)
         @(posedge clk);
      if (host_u.rxq.size() == 0)
      begin
         check(9'h000, {1'b1, exp});
         tally_and_finish();
      end
      else
         check(host_u.rxq.pop_front(), {1'b1, exp});
   endtask

   // Fresh memory: pattern below, blank top region
   task automatic restart(input logic sec);
      for (int i = 0; i < 65536; i++)
         mem[i] = (i >= 65504) ? 8'hff : i[7:0] ^ 8'h5a;
      sec_en <= sec;
      sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
      host_u.rxq.delete();
   endtask

   task automatic send24(input logic [23:0] v);
      for (int i = 2; i >= 0; i--)
         host_u.send(v[i * 8 +: 8], 1'b1, 1);
   endtask

   task automatic start_session(input logic [7:0] s1, input logic [7:0] s2, input logic sec);
      restart(sec);
      host_u.send(s1, 1'b1, 1);
      get(s1);
      host_u.send(s2, 1'b1, 2);
      get(s2);
      host_u.send(8'h40, 1'b1, 2);
      get(8'h40);
   endtask

   // Address and count, then the stream and its sum
   task automatic read_body(input logic [23:0] start, input logic [23:0] cnt);
      logic [15:0] sum;
      sum = 16'h0000;
      send24(start);
      send24(cnt);
      for (int i = 0; i < cnt; i++)
      begin
         get(mem[16'(start + i)]);
         sum = sum + 16'(mem[16'(start + i)]);
      end
      get(sum[15:8]);
      get(sum[7:0]);
   endtask

   // Long enough for several frames to have shown up
   task automatic quiet_check();
      repeat (800) @(posedge clk);
      check({host_u.rxq.size() != 0, 7'h00, locked}, 9'h001);
   endtask

   task automatic sc_blank_read();
      start_session(8'h86, 8'h79, 1'b0);
      send24(24'h000100);
      send24(24'h000200);
      read_body(24'h000010, 24'h000005);
      host_u.send(8'h40, 1'b1, 2);
      get(8'h40);
      send24(24'h000100);
      send24(24'h000200);
      read_body(24'h00fffe, 24'h000002);
      check({8'h00, locked}, 9'h000);
   endtask

   task automatic sc_alt_sync();
      start_session(8'h30, 8'hcf, 1'b0);
      send24(24'h000000);
      send24(24'h00ffe0);
      read_body(24'h000000, 24'h000001);
   endtask

   // Bad opcode, then framing error at the opcode
   task automatic sc_opcode_err();
      for (int k = 0; k < 2; k++)
      begin
         restart(1'b0);
         host_u.send(8'h86, 1'b1, 1);
         get(8'h86);
         host_u.send(8'h79, 1'b1, 2);
         get(8'h79);
         host_u.send(k ? 8'h40 : 8'h41, k == 0, 2);
         repeat (3) get(k ? 8'ha1 : 8'h63);
         quiet_check();
      end
   endtask

   // Bad address, zero count, big count, security on, framing slip
   task automatic sc_dead();
      for (int k = 0; k < 5; k++)
      begin
         start_session(8'h86, 8'h79, k == 3);
         send24(k == 0 ? 24'h010000 : 24'h000100);
         if (k == 4)
            host_u.send(8'h00, 1'b0, 1);
         else
            send24(24'h000200);
         if (k == 1 || k == 2)
         begin
            send24(24'h000000);
            send24(k == 1 ? 24'h000000 : 24'h010001);
         end
         quiet_check();
         host_u.send(8'h40, 1'b1, 2);
         quiet_check();
      end
   endtask

   // Protected part: right password streams, wrong one locks
   task automatic sc_password();
      for (int k = 0; k < 2; k++)
      begin
         start_session(8'h86, 8'h79, 1'b0);
         mem[16'hffe0] = 8'h00;
         mem[16'h1000] = 8'h02;
         mem[16'h1100] = 8'h3c;
         mem[16'h1101] = 8'hc3;
         send24(24'h001000);
         send24(24'h001100);
         host_u.send(8'h3c, 1'b1, 1);
         host_u.send(k ? 8'hc4 : 8'hc3, 1'b1, 1);
         if (k)
            quiet_check();
         else
            read_body(24'h000020, 24'h000003);
      end
   endtask

   initial
   begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      sec_en = 1'b0;
      mem_rdata = 8'h00;
      err_total = 0;
      samples_checked = 0;
      sc_blank_read();
      sc_alt_sync();
      sc_opcode_err();
      sc_dead();
      sc_password();
      tally_and_finish();
   end
endmodule

bind sbfr_top sbfr_top_props #(.BIT_T(8)) chk_u (.clk(clk), .sys_rst(sys_rst), .txd(txd), .mem_rd(mem_rd),
   .mem_addr(mem_addr), .locked(locked));
